// file: bench/configurable_async_serial_port_chk.sv
// Checker for the serial port top: APB handshake and transmit line timing.
// Assumes one clock domain and a bit period of at least 21 clocks.
`timescale 1ns/1ps
`default_nettype none
module configurable_async_serial_port_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic txd,
    input wire logic cts_n,
    input wire logic rts_n
);
    // ----------------
    // Properties
    // ----------------
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    ack_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ack_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    wait_state_a: assert property (psel && $rose(penable) |-> !pready)
        else $error("pready without wait state");
    ack_bound_a: assert property (psel && penable && !pready && !(pwrite && paddr == 32'hc)
        |-> ##1 pready) else $error("access not answered");
    err_with_ack_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (pready && (paddr > 32'h10 || paddr[1:0] != 2'h0)
        |-> pslverr) else $error("unmapped access not refused");
    mapped_ok_a: assert property (pready && paddr <= 32'h10 && paddr[1:0] == 2'h0
        |-> !pslverr) else $error("mapped access refused");
    err_read_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    bit_hold_a: assert property ($changed(txd) |=> $stable(txd)[*8])
        else $error("line bit too short");
    idle_after_reset_a: assert property ($fell(sys_rst) |-> txd && rts_n)
        else $error("line not idle after reset");
    cover property (pslverr);
    cover property ($fell(txd));
    cover property (!rts_n);
endmodule : configurable_async_serial_port_chk
`default_nettype wire

// file: bench/configurable_async_serial_port_tb_top.sv
// Testbench top for the serial port: APB master, serial peer, self-checks.
// Assumes the package, design, peer model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module configurable_async_serial_port_tb_top;
    import uart_pkg::*;
    localparam int DV = 21;
    localparam logic [31:0] A_CTRL = {24'h0, OFS_CTRL};
    localparam logic [31:0] A_DIV = {24'h0, OFS_DIV};
    localparam logic [31:0] A_STAT = {24'h0, OFS_STAT};
    localparam logic [31:0] A_TXD = {24'h0, OFS_TXD};
    localparam logic [31:0] A_RXD = {24'h0, OFS_RXD};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
    logic pready, pslverr, rxd, txd, cts_n, rts_n;
    int n_mismatch = 0, tests_run = 0, cyc = 0;

    configurable_async_serial_port i_configurable_async_serial_port (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
        .txd(txd), .cts_n(cts_n), .rts_n(rts_n));
    serial_peer i_serial_peer (.sys_clk(sys_clk), .txd(txd), .rts_n(rts_n), .rxd(rxd),
        .cts_n(cts_n));

    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            final_report();
        end
    end

    // ----------------
    // Bus and compare helpers
    // ----------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Idle edge at the end keeps back-to-back calls off one time step
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, r, exp);
    endtask : rdc
    function automatic logic [15:0] frm(input logic [7:0] d, input logic [6:0] c,
                                        output int nb);
        logic [7:0] m;
        logic p;
        int n;
        n = int'(c[1:0]) + 5;
        m = d & (8'hff >> (8 - n));
        p = c[5] ? ~c[4] : (c[4] ? ~^m : ^m);
        frm = '1;
        frm[0] = 1'b0;
        for (int i = 0; i < n; i++) frm[i + 1] = m[i];
        nb = n + 1;
        if (c[3]) begin
            frm[nb] = p;
            nb++;
        end
        nb += (c[2] && n > 5) ? 2 : 1;
    endfunction : frm

    // ----------------
    // Scenarios
    // ----------------
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        chk("txd idle", {31'h0, txd}, 32'h1);
        chk("rts off", {31'h0, rts_n}, 32'h1);
        rdc(A_CTRL, 32'h3, "ctrl reset");
        rdc(A_DIV, 32'had, "div reset");
        rdc(A_STAT, 32'h2, "stat reset");
        apb(1'b0, 32'h14, 32'h0, r, e);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        wr(A_DIV, 32'd16666);
        rdc(A_DIV, 32'd16666, "div slow");
        wr(A_DIV, DV);
        rdc(A_DIV, DV, "div fast");
    endtask : t_reset
    task automatic t_frame(input logic [6:0] c, input logic [7:0] d);
        logic [15:0] got, ft, fr;
        int nb, nr;
        ft = frm(d, c, nb);
        fr = frm(~d, c, nr);
        wr(A_CTRL, {25'h0, c});
        fork
            i_serial_peer.send(fr, nr, DV, 1'b0);
            wr(A_TXD, {24'h0, d});
            i_serial_peer.recv(got, nb, DV);
        join
        chk("tx frame", {16'h0, got}, {16'h0, ft});
        rdc(A_RXD, {24'h0, ~d & (8'hff >> (2'h3 - c[1:0]))}, "rx data");
        rdc(A_STAT, 32'h2, "stat clean");
        repeat (DV) @(posedge sys_clk);
    endtask : t_frame
    // Five bits with two stops requested: a single stop each way
    task automatic t_short;
        logic [15:0] got, f1, f2;
        int n1, n2;
        f1 = frm(8'h15, 7'h04, n1);
        f2 = frm(8'h0a, 7'h04, n2);
        wr(A_CTRL, 32'h4);
        fork
            begin
                wr(A_TXD, 32'h15);
                wr(A_TXD, 32'h0a);
            end
            i_serial_peer.recv(got, n1 + n2, DV);
            i_serial_peer.send({f2[8:0], f1[6:0]}, n1 + n2, DV, 1'b0);
        join
        chk("short pair", {16'h0, got}, {16'h0, f2[8:0], f1[6:0]});
        rdc(A_RXD, 32'h15, "short rx 1");
        rdc(A_RXD, 32'h0a, "short rx 2");
        repeat (DV) @(posedge sys_clk);
    endtask : t_short
    task automatic t_err;
        logic [15:0] f;
        logic [31:0] r;
        logic e;
        int n;
        f = frm(8'h5a, 7'h0f, n);
        f[9] = ~f[9];
        f[10] = 1'b0;
        wr(A_CTRL, 32'hf);
        i_serial_peer.send(f, n, DV, 1'b0);
        apb(1'b0, A_STAT, 32'h0, r, e);
        chk("rx errors", r & 32'h30, 32'h30);
        wr(A_STAT, 32'h30);
        apb(1'b0, A_RXD, 32'h0, r, e);
        chk("err rx data", r, 32'h5a);
        rdc(A_STAT, 32'h2, "errors cleared");
    endtask : t_err
    task automatic t_flow;
        logic [15:0] got;
        int n;
        wr(A_CTRL, 32'h43);
        i_serial_peer.hold(1'b1);
        @(posedge sys_clk);
        chk("rts ready", {31'h0, rts_n}, 32'h0);
        for (int i = 0; i < 8; i++) wr(A_TXD, 32'(i));
        rdc(A_STAT, 32'h1, "tx full");
        for (int i = 0; i < 8; i++) i_serial_peer.send(frm(8'(i + 128), 7'h43, n), 10, DV, 1'b1);
        repeat (2) @(posedge sys_clk);
        chk("rts full", {31'h0, rts_n}, 32'h1);
        chk("tx held", {31'h0, txd}, 32'h1);
        rdc(A_STAT, 32'hd, "both full");
        // One more character into a full receiver is dropped and flagged
        i_serial_peer.send(frm(8'h55, 7'h43, n), 10, DV, 1'b0);
        rdc(A_STAT, 32'h4d, "overrun");
        wr(A_STAT, 32'h40);
        rdc(A_STAT, 32'hd, "overrun clear");
        for (int i = 0; i < 8; i++) rdc(A_RXD, 32'(i + 128), "rx drain");
        chk("rts again", {31'h0, rts_n}, 32'h0);
        i_serial_peer.hold(1'b0);
        for (int i = 0; i < 8; i++) begin
            i_serial_peer.recv(got, 10, DV);
            chk("flow tx", {16'h0, got}, {16'h0, frm(8'(i), 7'h43, n)});
        end
    endtask : t_flow

    task automatic final_report;
        $display("Comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        t_reset();
        for (int l = 0; l < 4; l++) begin
            for (int p = 0; p < 5; p++) begin
                t_frame({1'b0, 2'(p), p < 4, 1'(p), 2'(l)}, 8'(8'h5c ^ (l * 16 + p)));
            end
        end
        t_short();
        t_err();
        t_flow();
        final_report();
    end
endmodule : configurable_async_serial_port_tb_top

bind configurable_async_serial_port configurable_async_serial_port_chk i_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n));
`default_nettype wire

// file: bench/serial_peer.sv
// Serial peer model: drives the receive line and samples the transmit line.
// Assumes the caller builds frames LSB first; bit period in system clocks.
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input wire logic sys_clk,
    input wire logic txd,
    input wire logic rts_n,
    output logic rxd,
    output logic cts_n
);
    // ----------------
    // Line tasks
    // ----------------
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
    end
    task automatic hold(input logic v);
        cts_n <= v;
    endtask : hold
    // Frames end on a high stop bit, so the line idles high afterwards
    task automatic send(input logic [15:0] b, input int nb, input int div, input logic fc);
        while (fc && rts_n) @(posedge sys_clk);
        for (int i = 0; i < nb; i++) begin
            rxd <= b[i];
            repeat (div) @(posedge sys_clk);
        end
    endtask : send
    // Returns at the middle of the last bit so back-to-back frames stay aligned
    task automatic recv(output logic [15:0] b, input int nb, input int div);
        b = '1;
        while (txd !== 1'b0) @(posedge sys_clk);
        repeat (div / 2) @(posedge sys_clk);
        for (int i = 0; i < nb; i++) begin
            if (i > 0) repeat (div) @(posedge sys_clk);
            b[i] = txd;
        end
    endtask : recv
endmodule : serial_peer
`default_nettype wire

// file: hdl/uart_port.sv
// Serial port: APB registers, TX/RX FIFOs, frame transmitter and receiver.
// Assumes APB master on sys_clk; line inputs already synchronous.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module uart_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0] cnt_q;
    logic push, pop;
    initial begin
        if (D < 2 || W < 1) $error("uart_fifo: depth must be at least 2");
    end
    assign in_ready = (cnt_q != (AW + 1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : uart_fifo

// Function
// - Bit period divisor covers 1200 to 921600 baud; peer uses same rate.
// - Transmitter and receiver run independently and concurrently.
// - RTS/CTS handshaking exists only on the flow-control-capable instance.
// - Character length selectable as five to eight data bits.
// - One or two stop bits on both transmit and receive.
// - Two stop bits with five data bits unsupported; one stop used.
// - Parity even, odd, mark or space; generated and checked.
module configurable_async_serial_port #(
    parameter bit FLOW_CONTROL_CAPABLE_PORT = 1'b1,
    parameter int unsigned DEPTH = uart_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    output logic txd,
    input wire logic cts_n,
    output logic rts_n
);
    import uart_pkg::*;
    initial begin
        if (DIV_MIN < 4) $error("Clock too slow for the top baud rate");
    end

    // ----------------------------------------
    // Registers and APB slave
    // ----------------------------------------
    logic [6:0] ctrl_q;
    logic [15:0] div_q;
    logic perr_q, ferr_q, ovr_q;
    logic ack_q, slverr_q;
    logic [31:0] prdata_q;
    logic tx_in_ready, tx_valid, tx_pop;
    logic [7:0] tx_data;
    logic rx_push_q, rx_in_ready, rx_valid, rx_pop;
    logic [7:0] rx_word_q, rx_data;
    logic set_perr, set_ferr, stop2, par_en, flow;
    logic [1:0] len, pmode;
    logic acc, wr_done, rd_done, bad;
    logic [7:0] ofs;
    logic [15:0] bit_cycles;

    assign len = ctrl_q[CTRL_LEN_LSB +: 2];
    assign stop2 = ctrl_q[CTRL_STOP2] && (len != 2'h0);
    assign par_en = ctrl_q[CTRL_PAR_EN];
    assign pmode = ctrl_q[CTRL_PAR_LSB +: 2];
    assign flow = FLOW_CONTROL_CAPABLE_PORT && ctrl_q[CTRL_FLOW];
    // Divisor is clamped into the supported baud range
    assign bit_cycles = (div_q < 16'(DIV_MIN)) ? 16'(DIV_MIN) :
                        (div_q > 16'(DIV_MAX)) ? 16'(DIV_MAX) : div_q;

    assign ofs = paddr[7:0];
    assign bad = (paddr[31:8] != 24'h0) || (ofs[1:0] != 2'h0) || (ofs > OFS_RXD);
    assign acc = psel && penable;
    // Refused transfers write nothing, pop nothing and read zero
    assign wr_done = acc && ack_q && pwrite && !slverr_q;
    assign rd_done = acc && ack_q && !pwrite && !slverr_q;
    assign pready = ack_q;
    assign prdata = prdata_q;
    assign pslverr = slverr_q && ack_q;

    // One wait state; TX data writes wait while the FIFO is full
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            prdata_q <= 32'h0;
            slverr_q <= 1'b0;
        end else if (ack_q || !acc) begin
            ack_q <= 1'b0;
        end else if (!(pwrite && !bad && ofs == OFS_TXD && !tx_in_ready)) begin
            ack_q <= 1'b1;
            slverr_q <= bad;
            case (bad ? 8'hff : ofs)
                OFS_CTRL: prdata_q <= {25'h0, ctrl_q};
                OFS_DIV: prdata_q <= {16'h0, div_q};
                OFS_STAT: prdata_q <= {25'h0, ovr_q, ferr_q, perr_q, !rx_in_ready,
                                       rx_valid, !tx_valid, !tx_in_ready};
                OFS_RXD: prdata_q <= {24'h0, rx_valid ? rx_data : 8'h00};
                default: prdata_q <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
            div_q <= DIV_RESET;
        end else if (wr_done && ofs == OFS_CTRL) begin
            ctrl_q <= pwdata[6:0];
        end else if (wr_done && ofs == OFS_DIV) begin
            div_q <= pwdata[15:0];
        end
    end

    // Sticky errors: write one to clear, a new event wins
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            perr_q <= set_perr || (perr_q && !(wr_done && ofs == OFS_STAT && pwdata[STAT_PERR]));
            ferr_q <= set_ferr || (ferr_q && !(wr_done && ofs == OFS_STAT && pwdata[STAT_FERR]));
            ovr_q <= (rx_push_q && !rx_in_ready) ||
                     (ovr_q && !(wr_done && ofs == OFS_STAT && pwdata[STAT_OVR]));
        end
    end
    assign rx_pop = rd_done && ofs == OFS_RXD;
    uart_fifo #(.W(8), .D(DEPTH)) tx_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(wr_done && ofs == OFS_TXD),
        .in_ready(tx_in_ready),
        .in_data(pwdata[7:0]),
        .out_valid(tx_valid),
        .out_ready(tx_pop),
        .out_data(tx_data)
    );

    uart_fifo #(.W(8), .D(DEPTH)) rx_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_valid(rx_push_q),
        .in_ready(rx_in_ready),
        .in_data(rx_word_q),
        .out_valid(rx_valid),
        .out_ready(rx_pop),
        .out_data(rx_data)
    );

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    frame_state_t tx_st_q;
    logic [15:0] tx_cnt_q;
    logic [7:0] tx_sh_q;
    logic [2:0] tx_idx_q;
    logic tx_sb_q, txd_q;

    assign txd = txd_q;
    // Start only when CTS allows; a frame in flight always completes
    assign tx_pop = (tx_st_q == ST_IDLE) && tx_valid && (!flow || !cts_n);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_st_q <= ST_IDLE;
            tx_cnt_q <= 16'h0;
            tx_sh_q <= 8'h0;
            tx_idx_q <= 3'h0;
            tx_sb_q <= 1'b0;
            txd_q <= 1'b1;
        end else if (tx_st_q == ST_IDLE) begin
            txd_q <= 1'b1;
            if (tx_pop) begin
                tx_st_q <= ST_START;
                tx_sh_q <= tx_data;
                tx_cnt_q <= bit_cycles - 16'h1;
                txd_q <= 1'b0;
            end
        end else if (tx_cnt_q != 16'h0) begin
            tx_cnt_q <= tx_cnt_q - 16'h1;
        end else begin
            tx_cnt_q <= bit_cycles - 16'h1;
            case (tx_st_q)
                ST_START: begin
                    tx_st_q <= ST_DATA;
                    tx_idx_q <= 3'h0;
                    txd_q <= tx_sh_q[0];
                end
                ST_DATA: begin
                    if (tx_idx_q == {1'b0, len} + 3'h4) begin
                        tx_st_q <= par_en ? ST_PAR : ST_STOP;
                        txd_q <= par_en ? parity_bit(tx_sh_q, len, pmode) : 1'b1;
                        tx_sb_q <= stop2;
                    end else begin
                        tx_idx_q <= tx_idx_q + 3'h1;
                        txd_q <= tx_sh_q[tx_idx_q + 3'h1];
                    end
                end
                ST_PAR: begin
                    tx_st_q <= ST_STOP;
                    txd_q <= 1'b1;
                end
                ST_STOP: begin
                    if (tx_sb_q) begin
                        tx_sb_q <= 1'b0;
                    end else begin
                        tx_st_q <= ST_IDLE;
                    end
                end
                default: tx_st_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    frame_state_t rx_st_q;
    logic [15:0] rx_cnt_q;
    logic [7:0] rx_sh_q, rx_aligned;
    logic [2:0] rx_idx_q;
    logic rx_sb_q, rx_tick;

    // Bits enter at the top, so shorter characters need a right shift
    assign rx_aligned = rx_sh_q >> (2'h3 - len);
    assign rx_tick = (rx_cnt_q == 16'h0);
    assign set_perr = (rx_st_q == ST_PAR) && rx_tick && par_en &&
                      (rxd != parity_bit(rx_aligned, len, pmode));
    assign set_ferr = (rx_st_q == ST_STOP) && rx_tick && !rxd;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_st_q <= ST_IDLE;
            rx_cnt_q <= 16'h0;
            rx_sh_q <= 8'h0;
            rx_idx_q <= 3'h0;
            rx_sb_q <= 1'b0;
            rx_push_q <= 1'b0;
            rx_word_q <= 8'h0;
        end else begin
            rx_push_q <= 1'b0;
            if (rx_st_q == ST_IDLE) begin
                if (!rxd) begin
                    rx_st_q <= ST_START;
                    rx_cnt_q <= bit_cycles >> 1;
                end
            end else if (!rx_tick) begin
                rx_cnt_q <= rx_cnt_q - 16'h1;
            end else begin
                rx_cnt_q <= bit_cycles - 16'h1;
                case (rx_st_q)
                    ST_START: begin
                        // A start bit gone by mid-bit is a glitch
                        rx_st_q <= rxd ? ST_IDLE : ST_DATA;
                        rx_idx_q <= 3'h0;
                    end
                    ST_DATA: begin
                        rx_sh_q <= {rxd, rx_sh_q[7:1]};
                        rx_idx_q <= rx_idx_q + 3'h1;
                        if (rx_idx_q == {1'b0, len} + 3'h4) begin
                            rx_st_q <= par_en ? ST_PAR : ST_STOP;
                            rx_sb_q <= stop2;
                        end
                    end
                    ST_PAR: rx_st_q <= ST_STOP;
                    ST_STOP: begin
                        if (rx_sb_q) begin
                            rx_sb_q <= 1'b0;
                        end else begin
                            rx_st_q <= ST_IDLE;
                            rx_push_q <= 1'b1;
                            rx_word_q <= len_mask(rx_aligned, len);
                        end
                    end
                    default: rx_st_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Flow control output
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rts_n <= 1'b1;
        end else begin
            rts_n <= !(flow && rx_in_ready);
        end
    end
endmodule : configurable_async_serial_port

`default_nettype wire

// file: shared/uart_pkg.sv
// Constants, register map and frame helpers for the serial port.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
package uart_pkg;
    // ----------------------------------------
    // Clock and line rates
    // ----------------------------------------
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BAUD_MIN = 1200;
    localparam int unsigned BAUD_MAX = 921600;
    localparam int unsigned DIV_MAX = CLK_HZ / BAUD_MIN;
    localparam int unsigned DIV_MIN = CLK_HZ / BAUD_MAX;
    localparam int unsigned FIFO_DEPTH = 8;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIV = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_TXD = 8'h0c;
    localparam logic [7:0] OFS_RXD = 8'h10;

    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int CTRL_LEN_LSB = 0;
    localparam int CTRL_STOP2 = 2;
    localparam int CTRL_PAR_EN = 3;
    localparam int CTRL_PAR_LSB = 4;
    localparam int CTRL_FLOW = 6;
    localparam int STAT_TX_FULL = 0;
    localparam int STAT_TX_EMPTY = 1;
    localparam int STAT_RX_VALID = 2;
    localparam int STAT_RX_FULL = 3;
    localparam int STAT_PERR = 4;
    localparam int STAT_FERR = 5;
    localparam int STAT_OVR = 6;
    localparam logic [6:0] CTRL_RESET = 7'h03;
    localparam logic [15:0] DIV_RESET = 16'h00ad;

    typedef enum logic [1:0] {
        PAR_EVEN = 2'h0,
        PAR_ODD = 2'h1,
        PAR_MARK = 2'h2,
        PAR_SPACE = 2'h3
    } parity_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_DATA = 5'h04,
        ST_PAR = 5'h08,
        ST_STOP = 5'h10
    } frame_state_t;

    // Keep only the bits of the selected character length
    function automatic logic [7:0] len_mask(input logic [7:0] d, input logic [1:0] len);
        len_mask = d & (8'hff >> (2'h3 - len));
    endfunction : len_mask

    function automatic logic parity_bit(input logic [7:0] d, input logic [1:0] len,
                                        input logic [1:0] mode);
        case (mode)
            PAR_EVEN: parity_bit = ^len_mask(d, len);
            PAR_ODD: parity_bit = ~^len_mask(d, len);
            PAR_MARK: parity_bit = 1'b1;
            default: parity_bit = 1'b0;
        endcase
    endfunction : parity_bit
endpackage : uart_pkg
